// File: inc/tif_pkg.sv
// Constants and types for the timer and event flag block
package tif_pkg;
  // Clock figures; the timer base is the crystal halved
  localparam int unsigned TIF_SYS_HZ     = 100_000_000;  // Fabric clock
  localparam int unsigned TIF_XTAL_HZ    = 27_120_000;   // Crystal
  localparam int unsigned TIF_TIMER_HZ   = TIF_XTAL_HZ / 2;  // 13.56 MHz timer base
  localparam int unsigned TIF_TICK_GRAIN = 40_000;       // Common divisor of both rates
  localparam logic [11:0] TIF_TICK_STEP  = 12'(TIF_TIMER_HZ / TIF_TICK_GRAIN);
  localparam logic [11:0] TIF_TICK_MOD   = 12'(TIF_SYS_HZ / TIF_TICK_GRAIN);

  // Register byte offsets
  localparam logic [7:0] TIF_OFS_ENABLES  = 8'h00;  // common_event_enables
  localparam logic [7:0] TIF_OFS_COMFLAGS = 8'h04;  // common_event_flags
  localparam logic [7:0] TIF_OFS_MSCFLAGS = 8'h08;  // misc_event_flags
  localparam logic [7:0] TIF_OFS_STATUS   = 8'h0C;  // primary_status_register
  localparam logic [7:0] TIF_OFS_CONTROL  = 8'h10;  // misc_control_register
  localparam logic [7:0] TIF_OFS_TMODE    = 8'h14;  // timer_mode_register
  localparam logic [7:0] TIF_OFS_PRESLO   = 8'h18;  // prescale_low_register
  localparam logic [7:0] TIF_OFS_RELOAD   = 8'h1C;  // counter_reload_register
  localparam logic [7:0] TIF_OFS_COUNT    = 8'h20;  // counter_value_register
  localparam logic [7:0] TIF_OFS_WATER    = 8'h24;  // fifo_watermark_field

  // Bit positions in the flag and enable registers
  localparam int TIF_B_TIMER = 0;
  localparam int TIF_B_ERR   = 1;
  localparam int TIF_B_LO    = 2;
  localparam int TIF_B_HI    = 3;
  localparam int TIF_B_IDLE  = 4;
  localparam int TIF_B_RX    = 5;
  localparam int TIF_B_TX    = 6;
  localparam int TIF_B_SET   = 7;  // Flag write: 1 sets marked bits, 0 clears
  localparam int TIF_B_CRCEN = 7;  // Enable register: crc_done_flag enable
  localparam int TIF_B_CRC   = 2;  // misc_event_flags position
  // Status bits
  localparam int TIF_S_LO    = 0;
  localparam int TIF_S_HI    = 1;
  localparam int TIF_S_RUN   = 3;
  localparam int TIF_S_PEND  = 4;
  localparam int TIF_S_CRCOK = 5;
  // Control and mode bits
  localparam int TIF_C_HALT   = 6;
  localparam int TIF_C_LAUNCH = 7;
  localparam int TIF_M_PERIOD = 4;
  localparam int TIF_M_AUTO   = 7;

  // Reset values and misc
  localparam logic [7:0]  TIF_RST_BYTE   = 8'h00;
  localparam logic [15:0] TIF_RST_WORD   = 16'h0000;
  localparam logic [5:0]  TIF_RST_WATER  = 6'h08;
  localparam logic [6:0]  TIF_FIFO_DEPTH = 7'h40;   // 64 byte FIFO
  localparam logic [3:0]  TIF_CMD_IDLE   = 4'h0;
  localparam logic [15:0] TIF_CNT_ONE    = 16'h0001;

  // Timer control states
  typedef enum logic {TIF_T_IDLE, TIF_T_RUN} tif_tstate_type;
endpackage

// File: rtl/tif_timer_irq.sv
// Event flag collection, interrupt pin and two stage timer behind Wishbone
`timescale 1ns/100ps
`default_nettype none

// Function
// - Report events by pending bit and pin
// - Timer flag sets on count 1 to 0
// - Transmit flag sets at end-of-frame start
// - CRC flag sets when CRC completes
// - Receive flag sets at stream end
// - Idle flag sets when command returns idle
// - Near-full flag sets on status rise
// - Near-empty flag sets on status rise
// - Error flag sets while any error bit
// - Timer expiry influences no other operation
// - Timer runs at 13.56 MHz rate
// - Prescaler reload from nibble plus byte
// - Counter reload is 16-bit register
// - Counter value readable any time
// - Zero reach sets timer flag, irq-able
// - Host may set or clear timer flag
// - At zero halt or reload by mode
// - Running status bit shows counting
// - Host launch and halt bits act
// - Auto bit lets protocol events launch
// - Delay is (2P+1) times (R+1)
// - Watermark rise drives pin when enabled
// - Near-full when 64 minus level within watermark
// - Near-empty when level within watermark
module tif_timer_irq (
  input  wire logic        clk_i,                // 100 MHz system clock
  input  wire logic        rst_i,                // Synchronous reset, high
  input  wire logic        wb_cyc_i,             // Wishbone cycle
  input  wire logic        wb_stb_i,             // Wishbone strobe
  input  wire logic        wb_we_i,              // Write enable
  input  wire logic [7:0]  wb_adr_i,             // Byte address
  input  wire logic [3:0]  wb_sel_i,             // Byte lanes
  input  wire logic [31:0] wb_dat_i,             // Write data
  output logic      [31:0] wb_dat_o,             // Read data
  output logic             wb_ack_o,             // Acknowledge
  input  wire logic        tx_frame_end_i,       // Transmitter entered end-of-frame
  input  wire logic        rx_stream_end_i,      // Receiver saw stream end
  input  wire logic        crc_complete_i,       // crc_complete_status level
  input  wire logic [3:0]  command_code_i,       // command_register code field
  input  wire logic [6:0]  fifo_level_i,         // Bytes stored in FIFO
  input  wire logic [7:0]  error_status_i,       // error_status_register bits
  input  wire logic        auto_launch_event_i,  // Protocol event that may launch
  output logic             irq_o,                // Interrupt request, high
  output logic             timer_active_o        // timer_active_status
);
  import tif_pkg::*;

  // Bus decode
  logic        req;        // New access this cycle
  logic        wr;         // Write strobe, lane 0
  logic        wr_hi;      // Write strobe, lane 1
  logic [7:0]  wdat;       // Lane 0 data
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i && wb_sel_i[0];
  assign wr_hi = req && wb_we_i && wb_sel_i[1];
  assign wdat  = wb_dat_i[7:0];

  // Software registers
  logic [7:0]  common_event_enables_reg;   // Flag enables
  logic [6:0]  common_event_flags_reg;     // Sticky flags
  logic        crc_done_flag_reg;          // misc_event_flags bit
  logic        auto_launch_bit_reg;        // Auto start
  logic        periodic_reg;               // Reload at zero
  logic [3:0]  prescale_upper_nibble_reg;  // Prescaler high
  logic [7:0]  prescale_lower_byte_reg;    // Prescaler low
  logic [15:0] counter_reload_value_reg;   // Counter reload
  logic [5:0]  fifo_watermark_field_reg;   // FIFO watermark

  // Timer state
  tif_tstate_type tstate_reg;              // Idle or counting
  logic [11:0] tick_acc_reg;               // Fractional rate accumulator
  logic        tick_reg;                   // 13.56 MHz rate strobe
  logic [12:0] presc_cnt_reg;              // Prescaler stage
  logic [15:0] counter_reg;                // Counter stage
  logic [12:0] presc_full;                 // Twice prescale value
  logic        presc_exp;                  // Prescaler stage expires
  logic        launch;                     // Start request
  logic        halt;                       // Stop request
  logic        timer_hit;                  // Counter goes 1 to 0
  logic        fresh_reg;                  // First period after launch

  // Event detection
  logic        hi_stat;                    // fifo_near_full_status
  logic        lo_stat;                    // fifo_near_empty_status
  logic        hi_stat_d_reg;              // Previous near-full
  logic        lo_stat_d_reg;              // Previous near-empty
  logic        crc_d_reg;                  // Previous CRC complete
  logic [3:0]  cmd_d_reg;                  // Previous command code
  logic [6:0]  set_ev;                     // Hardware set pulses
  logic        pending;                    // Any enabled flag

  // Watermark comparisons; 7-bit math keeps 64 minus level exact
  assign hi_stat = (TIF_FIFO_DEPTH - fifo_level_i) <= {1'b0, fifo_watermark_field_reg};
  assign lo_stat = fifo_level_i <= {1'b0, fifo_watermark_field_reg};

  // Edge history for level sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_stat_d_reg <= 1'b0;
      lo_stat_d_reg <= 1'b0;
      crc_d_reg     <= 1'b0;
      cmd_d_reg     <= TIF_CMD_IDLE;
    end else begin
      hi_stat_d_reg <= hi_stat;
      lo_stat_d_reg <= lo_stat;
      crc_d_reg     <= crc_complete_i;
      cmd_d_reg     <= command_code_i;
    end
  end

  // Hardware set conditions, one per flag position
  always_comb begin
    set_ev              = 7'h00;
    set_ev[TIF_B_TIMER] = timer_hit;
    set_ev[TIF_B_ERR]   = |error_status_i;
    set_ev[TIF_B_LO]    = lo_stat && !lo_stat_d_reg;
    set_ev[TIF_B_HI]    = hi_stat && !hi_stat_d_reg;
    set_ev[TIF_B_IDLE]  = (command_code_i == TIF_CMD_IDLE) && (cmd_d_reg != TIF_CMD_IDLE);
    set_ev[TIF_B_RX]    = rx_stream_end_i;
    set_ev[TIF_B_TX]    = tx_frame_end_i;
  end

  // Common flags: host sets or clears marked bits, hardware set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      common_event_flags_reg <= 7'h00;
    end else if (wr && wb_adr_i == TIF_OFS_COMFLAGS && wdat[TIF_B_SET]) begin
      common_event_flags_reg <= common_event_flags_reg | wdat[6:0] | set_ev;
    end else if (wr && wb_adr_i == TIF_OFS_COMFLAGS) begin
      common_event_flags_reg <= (common_event_flags_reg & ~wdat[6:0]) | set_ev;
    end else begin
      common_event_flags_reg <= common_event_flags_reg | set_ev;
    end
  end

  // CRC flag, same set and clear scheme
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_done_flag_reg <= 1'b0;
    end else if (crc_complete_i && !crc_d_reg) begin
      crc_done_flag_reg <= 1'b1;
    end else if (wr && wb_adr_i == TIF_OFS_MSCFLAGS && wdat[TIF_B_CRC]) begin
      crc_done_flag_reg <= wdat[TIF_B_SET];
    end
  end

  // Configuration registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      common_event_enables_reg  <= TIF_RST_BYTE;
      auto_launch_bit_reg       <= 1'b0;
      periodic_reg              <= 1'b0;
      prescale_upper_nibble_reg <= 4'h0;
      prescale_lower_byte_reg   <= TIF_RST_BYTE;
      counter_reload_value_reg  <= TIF_RST_WORD;
      fifo_watermark_field_reg  <= TIF_RST_WATER;
    end else begin
      if (wr && wb_adr_i == TIF_OFS_ENABLES) begin
        common_event_enables_reg <= wdat;
      end
      if (wr && wb_adr_i == TIF_OFS_TMODE) begin
        auto_launch_bit_reg       <= wdat[TIF_M_AUTO];
        periodic_reg              <= wdat[TIF_M_PERIOD];
        prescale_upper_nibble_reg <= wdat[3:0];
      end
      if (wr && wb_adr_i == TIF_OFS_PRESLO) begin
        prescale_lower_byte_reg <= wdat;
      end
      if (wr && wb_adr_i == TIF_OFS_RELOAD) begin
        counter_reload_value_reg[7:0] <= wdat;
      end
      if (wr_hi && wb_adr_i == TIF_OFS_RELOAD) begin
        counter_reload_value_reg[15:8] <= wb_dat_i[15:8];
      end
      if (wr && wb_adr_i == TIF_OFS_WATER) begin
        fifo_watermark_field_reg <= wdat[5:0];
      end
    end
  end

  // Rate strobe: average of 13.56 MHz ticks from 100 MHz, no second domain
  // One cycle of tick jitter buys a single clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_acc_reg <= 12'h000;
      tick_reg     <= 1'b0;
    end else if (tick_acc_reg + TIF_TICK_STEP >= TIF_TICK_MOD) begin
      tick_acc_reg <= tick_acc_reg + TIF_TICK_STEP - TIF_TICK_MOD;
      tick_reg     <= 1'b1;
    end else begin
      tick_acc_reg <= tick_acc_reg + TIF_TICK_STEP;
      tick_reg     <= 1'b0;
    end
  end

  // Prescaler lasts 2P+1 ticks, so stages multiply as documented
  assign presc_full = {prescale_upper_nibble_reg, prescale_lower_byte_reg, 1'b0};
  assign presc_exp  = (tstate_reg == TIF_T_RUN) && tick_reg && (presc_cnt_reg == 13'h0000);
  assign launch     = (wr && wb_adr_i == TIF_OFS_CONTROL && wdat[TIF_C_LAUNCH])
                   || (auto_launch_bit_reg && auto_launch_event_i);
  assign halt       = wr && wb_adr_i == TIF_OFS_CONTROL && wdat[TIF_C_HALT];
  assign timer_hit  = presc_exp && !fresh_reg && (counter_reg == TIF_CNT_ONE);

  // Timer control; a halt outranks a launch in the same write.
  // Expiry only raises the flag, nothing else in the device watches it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tstate_reg    <= TIF_T_IDLE;
      presc_cnt_reg <= 13'h0000;
      counter_reg   <= TIF_RST_WORD;
      fresh_reg     <= 1'b0;
    end else if (halt) begin
      tstate_reg <= TIF_T_IDLE;
    end else if (launch) begin
      tstate_reg    <= TIF_T_RUN;
      presc_cnt_reg <= presc_full;
      counter_reg   <= counter_reload_value_reg;
      fresh_reg     <= 1'b1;
    end else begin
      case (tstate_reg)
        TIF_T_IDLE: begin
          tstate_reg <= TIF_T_IDLE;  // Hold value for reading
        end
        TIF_T_RUN: begin
          if (presc_exp && fresh_reg) begin
            // Opening period only rearms: flag after R+1 periods
            presc_cnt_reg <= presc_full;
            fresh_reg     <= 1'b0;
          end else if (presc_exp && counter_reg == TIF_RST_WORD) begin
            // Zero reached earlier: reload or stop by mode
            presc_cnt_reg <= presc_full;
            if (periodic_reg) begin
              counter_reg <= counter_reload_value_reg;
            end else begin
              tstate_reg <= TIF_T_IDLE;
            end
          end else if (presc_exp) begin
            presc_cnt_reg <= presc_full;
            counter_reg   <= counter_reg - TIF_CNT_ONE;
          end else if (tick_reg) begin
            presc_cnt_reg <= presc_cnt_reg - 13'h0001;
          end
        end
        default: begin
          tstate_reg <= TIF_T_IDLE;
        end
      endcase
    end
  end

  // Pending summary and registered pin
  assign pending = |({crc_done_flag_reg, common_event_flags_reg} & common_event_enables_reg);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o          <= 1'b0;
      timer_active_o <= 1'b0;
    end else begin
      irq_o          <= pending;
      timer_active_o <= (tstate_reg == TIF_T_RUN);
    end
  end

  // Wishbone answer: ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          TIF_OFS_ENABLES:  wb_dat_o[7:0] <= common_event_enables_reg;
          TIF_OFS_COMFLAGS: wb_dat_o[6:0] <= common_event_flags_reg;
          TIF_OFS_MSCFLAGS: wb_dat_o[TIF_B_CRC] <= crc_done_flag_reg;
          TIF_OFS_STATUS: begin
            wb_dat_o[TIF_S_LO]    <= lo_stat;
            wb_dat_o[TIF_S_HI]    <= hi_stat;
            wb_dat_o[TIF_S_RUN]   <= (tstate_reg == TIF_T_RUN);
            wb_dat_o[TIF_S_PEND]  <= pending;
            wb_dat_o[TIF_S_CRCOK] <= crc_complete_i;
          end
          TIF_OFS_TMODE: begin
            wb_dat_o[TIF_M_AUTO]   <= auto_launch_bit_reg;
            wb_dat_o[TIF_M_PERIOD] <= periodic_reg;
            wb_dat_o[3:0]          <= prescale_upper_nibble_reg;
          end
          TIF_OFS_PRESLO:   wb_dat_o[7:0]  <= prescale_lower_byte_reg;
          TIF_OFS_RELOAD:   wb_dat_o[15:0] <= counter_reload_value_reg;
          TIF_OFS_COUNT:    wb_dat_o[15:0] <= counter_reg;
          TIF_OFS_WATER:    wb_dat_o[5:0]  <= fifo_watermark_field_reg;
          default:          wb_dat_o <= 32'h0000_0000;  // Control and unmapped read zero
        endcase
      end
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Timer sequencing
  AST_TIMER_FLAG: assert property (timer_hit |=> common_event_flags_reg[TIF_B_TIMER])
    else $error("timer flag missed at count 1 to 0");
  AST_ONESHOT_STOP: assert property ((presc_exp && counter_reg == TIF_RST_WORD
    && !periodic_reg && !fresh_reg && !halt && !launch) |=> ##1 !timer_active_o)
    else $error("one-shot timer kept running at zero");
  AST_PERIODIC: assert property ((presc_exp && counter_reg == TIF_RST_WORD
    && periodic_reg && !fresh_reg && !halt && !launch)
    |=> counter_reg == $past(counter_reload_value_reg))
    else $error("periodic timer did not reload");
  AST_HALT: assert property (halt |=> ##1 !timer_active_o)
    else $error("halt did not stop the timer");
  AST_LAUNCH: assert property ((launch && !halt) |=> ##1 timer_active_o
    && $past(counter_reg) == $past(counter_reload_value_reg, 2))
    else $error("launch did not load and run the timer");
  AST_FRESH: assert property ((presc_exp && fresh_reg && !halt && !launch)
    |=> counter_reg == $past(counter_reg))
    else $error("counter moved in the opening period");
  AST_PRESC: assert property ((presc_exp && !halt && !launch)
    |=> presc_cnt_reg == $past(presc_full))
    else $error("prescaler did not reload on expiry");
  AST_STEP: assert property ((presc_exp && !fresh_reg && counter_reg != TIF_RST_WORD
    && !halt && !launch) |=> counter_reg == $past(counter_reg) - TIF_CNT_ONE)
    else $error("counter did not step on expiry");

  // Flag sources
  AST_TX_FLAG: assert property (tx_frame_end_i |=> common_event_flags_reg[TIF_B_TX])
    else $error("transmit flag missed");
  AST_CRC_FLAG: assert property ($rose(crc_complete_i) |=> crc_done_flag_reg)
    else $error("crc flag missed");
  AST_RX_FLAG: assert property (rx_stream_end_i |=> common_event_flags_reg[TIF_B_RX])
    else $error("receive flag missed");
  AST_IDLE_FLAG: assert property ((command_code_i == TIF_CMD_IDLE
    && $past(command_code_i) != TIF_CMD_IDLE) |=> common_event_flags_reg[TIF_B_IDLE])
    else $error("idle flag missed");
  AST_HI_FLAG: assert property ($rose(hi_stat) |=> common_event_flags_reg[TIF_B_HI])
    else $error("near-full flag missed");
  AST_LO_FLAG: assert property ($rose(lo_stat) |=> common_event_flags_reg[TIF_B_LO])
    else $error("near-empty flag missed");
  AST_ERR_FLAG: assert property ((|error_status_i) |=> common_event_flags_reg[TIF_B_ERR])
    else $error("error flag missed");
  AST_HOST_SET: assert property ((wr && wb_adr_i == TIF_OFS_COMFLAGS
    && wdat[TIF_B_SET] && wdat[TIF_B_TIMER]) |=> common_event_flags_reg[TIF_B_TIMER])
    else $error("host could not set the timer flag");

  // Pin and bus
  AST_IRQ_PIN: assert property ((common_event_flags_reg[TIF_B_TIMER]
    && common_event_enables_reg[TIF_B_TIMER]) |=> irq_o)
    else $error("pin low with enabled timer flag");
  AST_IRQ_LOW: assert property ((({crc_done_flag_reg, common_event_flags_reg}
    & common_event_enables_reg) == 8'h00) |=> !irq_o)
    else $error("pin high with no enabled flag");
  AST_ACK: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ACK_REQ: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged next cycle");

  COV_EXPIRE: cover property (timer_hit ##1 irq_o);
  COV_PERIODIC: cover property (presc_exp && counter_reg == TIF_RST_WORD && periodic_reg);
  COV_HALT: cover property (timer_active_o ##1 halt);
  COV_ONESHOT_END: cover property (timer_active_o ##1 !timer_active_o);
  COV_AUTO: cover property (auto_launch_bit_reg && auto_launch_event_i);
endmodule

`default_nettype wire

// File: verif/tif_host_model.sv
// Host model: Wishbone classic master facing the block
`timescale 1ns/100ps
`default_nettype none
module tif_host_model (
  input  wire logic        clk_i,     // System clock
  input  wire logic        wb_ack_i,  // Slave acknowledge
  input  wire logic [31:0] wb_dat_i,  // Read data
  output logic             wb_cyc_o,  // Cycle
  output logic             wb_stb_o,  // Strobe
  output logic             wb_we_o,   // Write
  output logic      [7:0]  wb_adr_o,  // Byte address
  output logic      [3:0]  wb_sel_o,  // Byte lanes
  output logic      [31:0] wb_dat_o   // Write data
);
  // Idle bus at start
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end
  // One classic cycle; launch and halt reach the timer this way
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= adr;
    wb_sel_o <= we ? 4'h3 : 4'hF;
    wb_dat_o <= dat;
    // Hold everything until ack is sampled; only the bench watchdog ends a dead wait
    while (!ok) begin
      @(posedge clk_i);
      if (wb_ack_i === 1'b1) begin
        ok = 1'b1;
        rd = wb_dat_i;
      end
    end
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_dat_o <= ~dat;  // Stale data inverted so it never looks valid
  endtask
endmodule
`default_nettype wire

// File: verif/test_tif_timer_irq.sv
// Self-checking bench for the timer and event flag block
`timescale 1ns/100ps
`default_nettype none
module test_tif_timer_irq;
  import tif_pkg::*;
  logic        clk_i, rst_i;          // Clock and reset
  logic        cyc, stb, we, ack;     // Bus control
  logic [7:0]  adr;                   // Bus address
  logic [3:0]  sel;                   // Bus lanes
  logic [31:0] wdat, rdat;            // Bus data
  logic [2:0]  ev;                    // Pulses: tx end, rx end, auto launch
  logic        crc_ok, irq, active;   // CRC level and block outputs
  logic [3:0]  cmd;                   // Command code
  logic [6:0]  level;                 // FIFO fill
  logic [7:0]  err;                   // Error bits
  int          n_errors, n_compared;  // Tallies
  int          exp_c;                 // Cycles for nine timer ticks
  tif_timer_irq i_tif_timer_irq (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_frame_end_i(ev[0]), .rx_stream_end_i(ev[1]),
    .crc_complete_i(crc_ok), .command_code_i(cmd), .fifo_level_i(level),
    .error_status_i(err), .auto_launch_event_i(ev[2]), .irq_o(irq),
    .timer_active_o(active));
  tif_host_model i_tif_host_model (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat),
    .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
    .wb_dat_o(wdat));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        ok;
    i_tif_host_model.bus(1'b1, a, d, r, ok);
    chk("write ack", 32'h0000_0001, {31'h0, ok});
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        ok;
    i_tif_host_model.bus(1'b0, a, 32'h0000_0000, r, ok);
    chk("read ack", 32'h0000_0001, {31'h0, ok});
    chk(what, exp, r);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
  endtask
  // Read a flag, see the pin, clear it, see the pin drop
  task automatic flag_cycle(input string what, input logic [7:0] a, input int b);
    rdc(what, a, 32'h0000_0001 << b);
    chk("irq set", 32'h0000_0001, {31'h0, irq});
    wr(a, 32'h0000_0001 << b);
    rdc(what, a, 32'h0000_0000);
    chk("irq clear", 32'h0000_0000, {31'h0, irq});
  endtask
  // Wait for the pin, sampling right at each edge before that edge's updates land
  task automatic wait_irq(input string what);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < 500);
    chk(what, 32'h0000_0001, {31'h0, (n >= exp_c - 10 && n <= exp_c + 6)});
  endtask
  task automatic t_reset;
    rdc("enables", TIF_OFS_ENABLES, 32'h0000_0000);
    rdc("watermark", TIF_OFS_WATER, 32'h0000_0008);
    rdc("control", TIF_OFS_CONTROL, 32'h0000_0000);
    rdc("count", TIF_OFS_COUNT, 32'h0000_0000);
    wr(8'h3C, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h3C, 32'h0000_0000);
    wr(TIF_OFS_RELOAD, 32'h0000_A5C3);
    rdc("reload", TIF_OFS_RELOAD, 32'h0000_A5C3);
    wr(TIF_OFS_TMODE, 32'h0000_000F);
    rdc("mode", TIF_OFS_TMODE, 32'h0000_000F);
    wr(TIF_OFS_PRESLO, 32'h0000_00FF);
    rdc("prescale", TIF_OFS_PRESLO, 32'h0000_00FF);
  endtask
  task automatic t_events;
    wr(TIF_OFS_ENABLES, 32'h0000_00FF);
    pulse(0);
    flag_cycle("tx flag", TIF_OFS_COMFLAGS, TIF_B_TX);
    pulse(1);
    flag_cycle("rx flag", TIF_OFS_COMFLAGS, TIF_B_RX);
    @(posedge clk_i);
    cmd <= 4'h3;
    @(posedge clk_i);
    cmd <= TIF_CMD_IDLE;
    flag_cycle("idle flag", TIF_OFS_COMFLAGS, TIF_B_IDLE);
    @(posedge clk_i);
    err <= 8'h40;
    @(posedge clk_i);
    err <= 8'h00;
    flag_cycle("error flag", TIF_OFS_COMFLAGS, TIF_B_ERR);
    @(posedge clk_i);
    crc_ok <= 1'b1;
    rdc("crc status", TIF_OFS_STATUS, 32'h0000_0030);
    flag_cycle("crc flag", TIF_OFS_MSCFLAGS, TIF_B_CRC);
    @(posedge clk_i);
    crc_ok <= 1'b0;
  endtask
  task automatic t_fifo;
    @(posedge clk_i);
    level <= 7'h37;
    rdc("status 55", TIF_OFS_STATUS, 32'h0000_0000);
    @(posedge clk_i);
    level <= 7'h38;
    rdc("status 56", TIF_OFS_STATUS, 32'h0000_0012);
    flag_cycle("near full flag", TIF_OFS_COMFLAGS, TIF_B_HI);
    @(posedge clk_i);
    level <= 7'h09;
    rdc("status 9", TIF_OFS_STATUS, 32'h0000_0000);
    @(posedge clk_i);
    level <= 7'h08;
    rdc("status 8", TIF_OFS_STATUS, 32'h0000_0011);
    flag_cycle("near empty flag", TIF_OFS_COMFLAGS, TIF_B_LO);
    @(posedge clk_i);
    level <= 7'h20;
  endtask
  task automatic t_host_flag;
    wr(TIF_OFS_ENABLES, 32'h0000_0000);
    wr(TIF_OFS_COMFLAGS, 32'h0000_0081);
    rdc("host set", TIF_OFS_COMFLAGS, 32'h0000_0001);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(TIF_OFS_ENABLES, 32'h0000_0001);
    rdc("pending", TIF_OFS_STATUS, 32'h0000_0010);
    chk("irq enabled", 32'h0000_0001, {31'h0, irq});
    wr(TIF_OFS_COMFLAGS, 32'h0000_0001);
    rdc("host clear", TIF_OFS_COMFLAGS, 32'h0000_0000);
  endtask
  // Prescale 1, reload 2: flag after (2+1)*3 = nine ticks, then halts
  task automatic t_oneshot;
    wr(TIF_OFS_TMODE, 32'h0000_0000);
    wr(TIF_OFS_PRESLO, 32'h0000_0001);
    wr(TIF_OFS_RELOAD, 32'h0000_0002);
    wr(TIF_OFS_CONTROL, 32'h0000_0080);
    wait_irq("oneshot delay");
    repeat (exp_c / 3 + 8) @(posedge clk_i);
    rdc("stopped", TIF_OFS_STATUS, 32'h0000_0010);
    rdc("count zero", TIF_OFS_COUNT, 32'h0000_0000);
    chk("active low", 32'h0000_0000, {31'h0, active});
    wr(TIF_OFS_COMFLAGS, 32'h0000_0001);
  endtask
  // Reload 2 periodic: a flag every three prescaler periods
  task automatic t_periodic;
    wr(TIF_OFS_TMODE, 32'h0000_0010);
    wr(TIF_OFS_RELOAD, 32'h0000_0002);
    wr(TIF_OFS_CONTROL, 32'h0000_0080);
    @(posedge clk_i);
    chk("active high", 32'h0000_0001, {31'h0, active});
    wait_irq("first period");
    wr(TIF_OFS_COMFLAGS, 32'h0000_0001);
    wait_irq("second period");
    wr(TIF_OFS_CONTROL, 32'h0000_0040);
    rdc("halted", TIF_OFS_STATUS, 32'h0000_0010);
    chk("active off", 32'h0000_0000, {31'h0, active});
    wr(TIF_OFS_COMFLAGS, 32'h0000_0001);
  endtask
  task automatic t_auto;
    wr(TIF_OFS_TMODE, 32'h0000_0000);
    wr(TIF_OFS_RELOAD, 32'h0000_FFFF);
    pulse(2);
    rdc("no auto", TIF_OFS_STATUS, 32'h0000_0000);
    wr(TIF_OFS_TMODE, 32'h0000_0080);
    pulse(2);
    rdc("auto run", TIF_OFS_STATUS, 32'h0000_0008);
    chk("auto active", 32'h0000_0001, {31'h0, active});
    wr(TIF_OFS_CONTROL, 32'h0000_0040);
    rdc("auto halted", TIF_OFS_STATUS, 32'h0000_0000);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    n_errors = 0;
    n_compared = 0;
    exp_c = 9 * int'(TIF_TICK_MOD) / int'(TIF_TICK_STEP);
    rst_i = 1'b1;
    ev = 3'h0;
    crc_ok = 1'b0;
    cmd = 4'h0;
    level = 7'h20;
    err = 8'h00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_events;
    t_fifo;
    t_host_flag;
    t_oneshot;
    t_periodic;
    t_auto;
    end_sim;
  end
  // Watchdog: the whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
